// ==== pkg/fcs_defs.svh ====
// constants of the flash command sequencer: addresses, command bytes, timing
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
`define FCS_ADDR_555 12'h555
`define FCS_ADDR_AAA 12'hAAA
`define FCS_CMD_UNLK1 8'hAA
`define FCS_CMD_UNLK2 8'h55
`define FCS_CMD_PROG 8'hA0
`define FCS_CMD_ERASE 8'h80
`define FCS_CMD_SECT 8'h30
`define FCS_CMD_BULK 8'h10
`define FCS_CMD_SUSP 8'hB0
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_BYPASS 8'h20
`define FCS_CMD_AUTOSEL 8'h90
`define FCS_CMD_BYP_EXIT 8'h00
`define FCS_SEL_IDENT 3'h1
`define FCS_SEL_PROT 3'h2
`define FCS_PROT_YES 8'h01
`define FCS_PROT_NO 8'h00
`define FCS_PRIM_SECTORS 8
`define FCS_SEC_SECTORS 4
`define FCS_PRIM_SECT_KB 32
`define FCS_SEC_SECT_KB 16
`define FCS_CLK_MHZ 25
`define FCS_WINDOW_US 80
`define FCS_WINDOW_CYC (`FCS_WINDOW_US * `FCS_CLK_MHZ)
`define FCS_PROG_US 10
`define FCS_PROG_CYC (`FCS_PROG_US * `FCS_CLK_MHZ)
`define FCS_ERASE_US 1000
`define FCS_ERASE_CYC (`FCS_ERASE_US * `FCS_CLK_MHZ)
`define FCS_TMR_W 24
`define FCS_RB_BUSY 1'b0
`define FCS_RB_READY 1'b1
`endif

// ==== pkg/fcs_pkg.sv ====
// types of the flash command sequencer
package fcs_pkg;
  typedef enum logic [3:0] {
    ST_READ, ST_C1, ST_C2, ST_PROG_DATA, ST_ER1, ST_ER2, ST_ER3, ST_ER_WIN,
    ST_BUSY, ST_SUSP, ST_SBUSY, ST_ID_RD, ST_BYPASS, ST_BYP_PROG, ST_BYP_RST
  } fcs_state_type;
  typedef enum logic [1:0] {
    OP_PROG, OP_SECT_ERASE, OP_BULK_ERASE
  } fcs_op_type;
endpackage

// ==== rtl/fcs_sync.sv ====
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/10ps
module fcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] stable
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // per-bit agreement filter
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // register chain
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign stable = out_q;
endmodule

// ==== rtl/fcs_timer.sv ====
// loadable down counter with pause and a one-cycle expiry pulse
`timescale 1ns/10ps
module fcs_timer #(
  parameter int W = 24
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] val,
  input wire logic hold,
  output logic done,
  output logic busy
);
  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  // count down unless paused, load wins
  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = val;
    end else if (cnt_q != '0 && !hold) begin
      cnt_d = cnt_q - W'(1);
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign busy = (cnt_q != '0);
endmodule

// ==== rtl/fcs_seq.sv ====
// flash command sequencer: decodes host write sequences into flash operations
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_seq #(
  parameter logic [7:0] PRIM_ID = 8'h5A, // arbitrary identifier value
  parameter int unsigned PROG_CYCLES = `FCS_PROG_CYC,
  parameter int unsigned ERASE_CYCLES = `FCS_ERASE_CYC,
  parameter int unsigned WINDOW_CYCLES = `FCS_WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic write_strobe_pin_n,
  input wire logic read_strobe_n,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] primary_sector_select,
  input wire logic [3:0] secondary_sector_select,
  input wire logic [11:0] sector_protect,
  output logic ready_busy_pin,
  output logic erase_suspended,
  output logic rd_override,
  output logic [7:0] rd_data,
  output logic op_start,
  output fcs_pkg::fcs_op_type op_kind,
  output logic op_array,
  output logic [15:0] op_addr,
  output logic [7:0] op_data,
  output logic [11:0] op_sectors
);
  localparam int TW = `FCS_TMR_W;
  logic s_wr_n, s_rd_n;
  logic [15:0] s_addr;
  logic [7:0] s_wdata, s_psel;
  logic [3:0] s_ssel;

  // all host pins cross through one synchroniser so they stay aligned
  fcs_sync #(.W(38), .INIT({2'b11, 36'h0})) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin({write_strobe_pin_n, read_strobe_n, bus_addr, bus_wdata,
          primary_sector_select, secondary_sector_select}),
    .stable({s_wr_n, s_rd_n, s_addr, s_wdata, s_psel, s_ssel})
  );

  // bus capture state
  logic wr_prev_q, wr_prev_d, rd_prev_q, rd_prev_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d, psel_q, psel_d, rd_data_q, rd_data_d;
  logic [3:0] ssel_q, ssel_d;
  logic wr_rise, rd_fall;

  assign wr_rise = !wr_prev_q && s_wr_n;
  assign rd_fall = rd_prev_q && !s_rd_n;

  // address and selects on strobe fall, data held to strobe rise
  always_comb begin
    wr_prev_d = s_wr_n;
    rd_prev_d = s_rd_n;
    addr_d = addr_q;
    psel_d = psel_q;
    ssel_d = ssel_q;
    wdata_d = wdata_q;
    if (wr_prev_q && !s_wr_n) begin
      addr_d = s_addr;
      psel_d = s_psel;
      ssel_d = s_ssel;
    end
    if (!s_wr_n) begin
      wdata_d = s_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      psel_q <= 8'h00;
      ssel_q <= 4'h0;
    end else begin
      wr_prev_q <= wr_prev_d;
      rd_prev_q <= rd_prev_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      psel_q <= psel_d;
      ssel_q <= ssel_d;
    end
  end

  // command decode
  logic is555, isaaa, any_sel, arr_sec, hit_prot, wr_ev;
  logic [11:0] sel12, arr_mask;
  assign is555 = (addr_q[11:0] == `FCS_ADDR_555);
  assign isaaa = (addr_q[11:0] == `FCS_ADDR_AAA);
  assign sel12 = {ssel_q, psel_q};
  assign arr_sec = !(|psel_q) && (|ssel_q);
  assign any_sel = (|psel_q) || (|ssel_q);
  assign arr_mask = arr_sec ? 12'hF00 : 12'h0FF;
  assign hit_prot = |(sel12 & sector_protect);
  assign wr_ev = wr_rise && any_sel;

  // sequencer state
  fcs_pkg::fcs_state_type st_q, st_d, base;
  logic bypass_q, bypass_d, susp_q, susp_d, op_start_q, op_start_d;
  logic op_array_q, op_array_d, go_prog, go_erase;
  fcs_pkg::fcs_op_type op_kind_q, op_kind_d, er_kind;
  logic [15:0] op_addr_q, op_addr_d;
  logic [7:0] op_data_q, op_data_d;
  logic [11:0] op_sect_q, op_sect_d, er_mask_q, er_mask_d;
  logic op_load, win_load, op_done, win_done, op_busy, win_busy;
  logic [TW-1:0] op_val, win_val;
  logic mid;

  assign base = bypass_q ? fcs_pkg::ST_BYPASS :
                susp_q ? fcs_pkg::ST_SUSP : fcs_pkg::ST_READ;
  assign mid = (st_q == fcs_pkg::ST_C1) || (st_q == fcs_pkg::ST_C2) ||
               (st_q == fcs_pkg::ST_PROG_DATA) || (st_q == fcs_pkg::ST_ER1) ||
               (st_q == fcs_pkg::ST_ER2) || (st_q == fcs_pkg::ST_ER3) ||
               (st_q == fcs_pkg::ST_BYP_PROG) || (st_q == fcs_pkg::ST_BYP_RST);

  // next-state decode of each write byte
  always_comb begin
    st_d = st_q;
    bypass_d = bypass_q;
    susp_d = susp_q;
    er_mask_d = er_mask_q;
    er_kind = fcs_pkg::OP_SECT_ERASE;
    go_prog = 1'b0;
    go_erase = 1'b0;
    win_load = 1'b0;
    win_val = TW'(WINDOW_CYCLES);
    op_load = 1'b0;
    op_val = TW'(PROG_CYCLES);
    op_start_d = 1'b0;
    op_kind_d = op_kind_q;
    op_array_d = op_array_q;
    op_addr_d = op_addr_q;
    op_data_d = op_data_q;
    op_sect_d = op_sect_q;
    if (wr_ev) begin
      case (st_q)
        fcs_pkg::ST_READ, fcs_pkg::ST_SUSP: begin
          if (wdata_q == `FCS_CMD_UNLK1 && is555) begin
            st_d = fcs_pkg::ST_C1;
          end else if (susp_q && wdata_q == `FCS_CMD_SECT) begin
            st_d = fcs_pkg::ST_BUSY;
            susp_d = 1'b0;
          end
          // any other write is dropped, nothing is stored
        end
        fcs_pkg::ST_C1: st_d = (wdata_q == `FCS_CMD_UNLK2 && isaaa) ? fcs_pkg::ST_C2 : base;
        fcs_pkg::ST_C2: begin
          st_d = base;
          if (is555) begin
            case (wdata_q)
              `FCS_CMD_PROG: st_d = fcs_pkg::ST_PROG_DATA;
              `FCS_CMD_AUTOSEL: st_d = fcs_pkg::ST_ID_RD;
              `FCS_CMD_ERASE: if (!susp_q) st_d = fcs_pkg::ST_ER1;
              `FCS_CMD_BYPASS: begin
                if (!susp_q) begin
                  st_d = fcs_pkg::ST_BYPASS;
                  bypass_d = 1'b1;
                end
              end
              default: st_d = base;
            endcase
          end
        end
        fcs_pkg::ST_PROG_DATA, fcs_pkg::ST_BYP_PROG: go_prog = 1'b1;
        fcs_pkg::ST_ER1: st_d = (wdata_q == `FCS_CMD_UNLK1 && is555) ? fcs_pkg::ST_ER2 : base;
        fcs_pkg::ST_ER2: st_d = (wdata_q == `FCS_CMD_UNLK2 && isaaa) ? fcs_pkg::ST_ER3 : base;
        fcs_pkg::ST_ER3: begin
          if (wdata_q == `FCS_CMD_SECT) begin
            er_mask_d = sel12 & ~sector_protect;
            st_d = fcs_pkg::ST_ER_WIN;
          end else if (wdata_q == `FCS_CMD_BULK && is555) begin
            er_mask_d = arr_mask & ~sector_protect;
            er_kind = fcs_pkg::OP_BULK_ERASE;
            go_erase = 1'b1;
          end else begin
            st_d = base;
          end
        end
        fcs_pkg::ST_ER_WIN: begin
          if (wdata_q == `FCS_CMD_SECT) begin
            er_mask_d = er_mask_q | (sel12 & ~sector_protect);
          end else begin
            st_d = base;
          end
        end
        fcs_pkg::ST_BUSY: begin
          if (wdata_q == `FCS_CMD_SUSP && op_kind_q == fcs_pkg::OP_SECT_ERASE) begin
            st_d = fcs_pkg::ST_SUSP;
            susp_d = 1'b1;
          end
        end
        fcs_pkg::ST_ID_RD: if (wdata_q == `FCS_CMD_RESET) st_d = base;
        fcs_pkg::ST_BYPASS: begin
          if (wdata_q == `FCS_CMD_PROG) st_d = fcs_pkg::ST_BYP_PROG;
          else if (wdata_q == `FCS_CMD_AUTOSEL) st_d = fcs_pkg::ST_BYP_RST;
        end
        fcs_pkg::ST_BYP_RST: begin
          st_d = fcs_pkg::ST_BYPASS;
          if (wdata_q == `FCS_CMD_BYP_EXIT) begin
            st_d = fcs_pkg::ST_READ;
            bypass_d = 1'b0;
          end
        end
        default: st_d = st_q;
      endcase
    end else if (win_done) begin
      if (st_q == fcs_pkg::ST_ER_WIN) begin
        go_erase = 1'b1;
      end else if (mid) begin
        st_d = base;
      end
    end
    // completions win over a write landing in the same cycle
    if (win_done && st_q == fcs_pkg::ST_SBUSY) begin
      st_d = fcs_pkg::ST_SUSP;
    end
    if (op_done && st_q == fcs_pkg::ST_BUSY) begin
      st_d = base;
      susp_d = 1'b0;
    end
    // launch a program unless protected or inside the suspended erase
    if (go_prog) begin
      st_d = base;
      if (!hit_prot && !(susp_q && |(sel12 & er_mask_q))) begin
        op_start_d = 1'b1;
        op_kind_d = fcs_pkg::OP_PROG;
        op_array_d = arr_sec;
        op_addr_d = addr_q;
        op_data_d = wdata_q;
        op_sect_d = sel12;
        if (susp_q) begin
          st_d = fcs_pkg::ST_SBUSY;
          win_load = 1'b1;
          win_val = TW'(PROG_CYCLES);
        end else begin
          st_d = fcs_pkg::ST_BUSY;
          op_load = 1'b1;
        end
      end
    end
    // launch an erase when some target sector is unprotected
    if (go_erase) begin
      st_d = base;
      if (|er_mask_d) begin
        op_start_d = 1'b1;
        op_kind_d = er_kind;
        op_array_d = arr_sec;
        op_addr_d = addr_q;
        op_sect_d = er_mask_d;
        st_d = fcs_pkg::ST_BUSY;
        op_load = 1'b1;
        op_val = TW'(ERASE_CYCLES);
      end
    end
    // every byte inside a sequence restarts the byte window
    if (wr_ev && !go_prog && (st_d == fcs_pkg::ST_C1 || st_d == fcs_pkg::ST_C2 ||
        st_d == fcs_pkg::ST_PROG_DATA || st_d == fcs_pkg::ST_ER1 ||
        st_d == fcs_pkg::ST_ER2 || st_d == fcs_pkg::ST_ER3 ||
        st_d == fcs_pkg::ST_ER_WIN || st_d == fcs_pkg::ST_BYP_PROG ||
        st_d == fcs_pkg::ST_BYP_RST)) begin
      win_load = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= fcs_pkg::ST_READ;
      bypass_q <= 1'b0;
      susp_q <= 1'b0;
      er_mask_q <= 12'h000;
      op_start_q <= 1'b0;
      op_kind_q <= fcs_pkg::OP_PROG;
      op_array_q <= 1'b0;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
      op_sect_q <= 12'h000;
    end else begin
      st_q <= st_d;
      bypass_q <= bypass_d;
      susp_q <= susp_d;
      er_mask_q <= er_mask_d;
      op_start_q <= op_start_d;
      op_kind_q <= op_kind_d;
      op_array_q <= op_array_d;
      op_addr_q <= op_addr_d;
      op_data_q <= op_data_d;
      op_sect_q <= op_sect_d;
    end
  end

  // embedded cycle timer, paused while the erase is suspended
  fcs_timer #(.W(TW)) u_op_tmr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(op_load),
    .val(op_val),
    .hold(susp_d), // no last tick lost on the suspend edge
    .done(op_done),
    .busy(op_busy)
  );

  // byte window timer, also times programs made during suspend
  fcs_timer #(.W(TW)) u_win_tmr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(win_load),
    .val(win_val),
    .hold(1'b0),
    .done(win_done),
    .busy(win_busy)
  );

  // readout answers on read strobe fall in identifier mode
  logic [2:0] rsel;
  assign rsel = {s_addr[6], s_addr[1], s_addr[0]};
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_fall && st_q == fcs_pkg::ST_ID_RD) begin
      rd_data_d = `FCS_PROT_NO;
      if (rsel == `FCS_SEL_IDENT && |s_psel) begin
        rd_data_d = PRIM_ID;
      end else if (rsel == `FCS_SEL_PROT && |({s_ssel, s_psel} & sector_protect)) begin
        rd_data_d = `FCS_PROT_YES;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_override = (st_q == fcs_pkg::ST_ID_RD) && !s_rd_n;
  assign ready_busy_pin = (st_q == fcs_pkg::ST_BUSY || st_q == fcs_pkg::ST_SBUSY) ?
                          `FCS_RB_BUSY : `FCS_RB_READY;
  assign erase_suspended = susp_q;
  assign rd_data = rd_data_q;
  assign op_start = op_start_q;
  assign op_kind = op_kind_q;
  assign op_array = op_array_q;
  assign op_addr = op_addr_q;
  assign op_data = op_data_q;
  assign op_sectors = op_sect_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence prog_cmd_s;
    st_q == fcs_pkg::ST_C2 && wr_ev && is555 && wdata_q == `FCS_CMD_PROG;
  endsequence
  sequence prog_data_s;
    st_q == fcs_pkg::ST_PROG_DATA && wr_ev && !hit_prot && !susp_q;
  endsequence

  op_busy_low_a: assert property (op_start_q |-> !ready_busy_pin)
    else $error("ready/busy not low at operation start");
  prot_guard_a: assert property (op_start_q |-> (op_sect_q & sector_protect) == 12'h000)
    else $error("operation touches a protected sector");
  plain_write_a: assert property (st_q == fcs_pkg::ST_READ && wr_rise |=> !op_start_q)
    else $error("plain write started an operation");
  unlock_step_a: assert property (st_q == fcs_pkg::ST_READ && wr_ev && is555 &&
      wdata_q == `FCS_CMD_UNLK1 |=> st_q == fcs_pkg::ST_C1)
    else $error("first unlock byte not taken");
  prog_cmd_a: assert property (prog_cmd_s |=> st_q == fcs_pkg::ST_PROG_DATA)
    else $error("program command byte not taken");
  prog_launch_a: assert property (prog_data_s |=>
      op_start_q && op_kind_q == fcs_pkg::OP_PROG && op_addr_q == $past(addr_q))
    else $error("byte program not launched");
  busy_timer_a: assert property (!ready_busy_pin |->
      ((st_q == fcs_pkg::ST_BUSY) ? (op_busy || op_done) : (win_busy || win_done)))
    else $error("busy without a running timer");
  seq_timeout_a: assert property (win_done && mid && !wr_ev && !bypass_q && !susp_q
      |=> st_q == fcs_pkg::ST_READ)
    else $error("timeout did not return to read");
  erase_suspend_a: assert property (st_q == fcs_pkg::ST_BUSY && wr_ev && !op_done &&
      wdata_q == `FCS_CMD_SUSP && op_kind_q == fcs_pkg::OP_SECT_ERASE
      |=> susp_q && ready_busy_pin ##1 susp_q)
    else $error("sector erase not suspended");
  erase_resume_a: assert property (st_q == fcs_pkg::ST_SUSP && wr_ev &&
      wdata_q == `FCS_CMD_SECT |=> !susp_q && !ready_busy_pin)
    else $error("suspended erase not resumed");
  ident_read_a: assert property (st_q == fcs_pkg::ST_ID_RD && rd_fall &&
      rsel == `FCS_SEL_IDENT && |s_psel |=> rd_data_q == PRIM_ID)
    else $error("identifier readout wrong");
endmodule

// ==== bench/fcs_host_model.sv ====
// host bus model: drives write and read cycles onto the sequencer pins
`timescale 1ns/10ps
module fcs_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_override,
  output logic write_strobe_pin_n,
  output logic read_strobe_n,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic [7:0] primary_sector_select,
  output logic [3:0] secondary_sector_select
);
  // idle bus: strobes high, selects low
  initial begin
    write_strobe_pin_n = 1'b1;
    read_strobe_n = 1'b1;
    bus_addr = 16'hA5A5;
    bus_wdata = 8'h5A;
    primary_sector_select = 8'h00;
    secondary_sector_select = 4'h0;
  end
  // released address and data lines flip and selects go low, so no stale value survives
  task automatic idle(input int n);
    @(posedge sys_clk);
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
    {secondary_sector_select, primary_sector_select} <= 12'h000;
    repeat (n) @(posedge sys_clk);
  endtask
  // one write cycle, everything held until after the strobe rises
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [11:0] sel);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    {secondary_sector_select, primary_sector_select} <= sel;
    write_strobe_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    write_strobe_pin_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    idle(2);
  endtask
  // one read cycle, answer taken while the strobe is still low
  task automatic rd(input logic [15:0] a, input logic [11:0] sel, output logic [7:0] d,
                    output logic ov);
    @(posedge sys_clk);
    bus_addr <= a;
    {secondary_sector_select, primary_sector_select} <= sel;
    read_strobe_n <= 1'b0;
    repeat (7) @(posedge sys_clk);
    d = rd_data;
    ov = rd_override;
    read_strobe_n <= 1'b1;
    idle(4);
  endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench of the flash command sequencer
`timescale 1ns/10ps
`include "fcs_defs.svh"
module testbench;
  localparam int PROG = 8;
  localparam int ERASE = 40;
  localparam int WIN = 16;
  localparam logic [7:0] ID = 8'hC3; // arbitrary identifier value
  logic sys_clk, nrst, wr_n, rd_n, rb, susp, ovr, ost, oarr;
  logic [15:0] addr, oaddr;
  logic [7:0] wdata, psel, rdd, odata;
  logic [3:0] ssel;
  logic [11:0] sector_protect, osect;
  fcs_pkg::fcs_op_type okind, s_kind;
  logic [11:0] s_sect;
  logic [15:0] s_addr;
  logic [7:0] s_data;
  logic s_arr;
  int op_count = 0, busy_run = 0, last_busy = 0, bad_count = 0, compares = 0, cyc = 0;

  fcs_seq #(.PRIM_ID(ID), .PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE), .WINDOW_CYCLES(WIN))
  i_fcs_seq (.sys_clk(sys_clk), .nrst(nrst), .write_strobe_pin_n(wr_n), .read_strobe_n(rd_n),
    .bus_addr(addr), .bus_wdata(wdata), .primary_sector_select(psel),
    .secondary_sector_select(ssel), .sector_protect(sector_protect), .ready_busy_pin(rb),
    .erase_suspended(susp), .rd_override(ovr), .rd_data(rdd), .op_start(ost),
    .op_kind(okind), .op_array(oarr), .op_addr(oaddr), .op_data(odata), .op_sectors(osect));
  fcs_host_model i_fcs_host_model (.sys_clk(sys_clk), .rd_data(rdd), .rd_override(ovr),
    .write_strobe_pin_n(wr_n), .read_strobe_n(rd_n), .bus_addr(addr), .bus_wdata(wdata),
    .primary_sector_select(psel), .secondary_sector_select(ssel));

  // clock, 40 ns period
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // launch snapshot, busy length and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (ost === 1'b1) begin
      op_count++;
      s_kind = okind;
      s_sect = osect;
      s_addr = oaddr;
      s_data = odata;
      s_arr = oarr;
    end
    if (rb === 1'b0) busy_run++;
    else if (busy_run != 0) begin
      last_busy = busy_run;
      busy_run = 0;
    end
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] hi(input logic [11:0] lo);
    logic [3:0] top;
    top = 4'($urandom);
    return {top, lo};
  endfunction
  function automatic logic [15:0] ev();
    return 16'($urandom) & 16'hFFFE;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [11:0] s);
    i_fcs_host_model.wr(a, d, s);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [11:0] s);
    wr(hi(`FCS_ADDR_555), `FCS_CMD_UNLK1, s);
    wr(hi(`FCS_ADDR_AAA), `FCS_CMD_UNLK2, s);
    if (c !== 8'hFF) wr(hi(`FCS_ADDR_555), c, s);
  endtask
  task automatic expect_op(input int prev, input fcs_pkg::fcs_op_type k,
                           input logic [11:0] sect, input logic arr);
    for (int i = 0; i < 80 && op_count == prev; i++) @(posedge sys_clk);
    chk(op_count - prev, 1);
    chk(s_kind, k);
    chk(s_sect, sect);
    chk(s_arr, arr);
  endtask
  task automatic no_op(input int prev);
    repeat (30) @(posedge sys_clk);
    chk(op_count, prev);
  endtask
  task automatic busy_chk(input int n);
    for (int i = 0; i < 400 && rb !== 1'b1; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    chk((last_busy == n) || (last_busy == n + 1), 1'b1);
  endtask

  // main sequence
  initial begin
    int prev, idx, seg;
    logic [11:0] s, prot;
    logic [15:0] a;
    logic [7:0] d;
    logic ov;
    void'($urandom(37));
    nrst = 1'b0;
    sector_protect = 12'h000;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    chk(rb, `FCS_RB_READY);
    chk(susp, 1'b0);
    repeat (6) @(posedge sys_clk);
    $display("test reset done");
    // random programs, every other target protected
    for (int n = 0; n < 8; n++) begin
      idx = $urandom % 12;
      s = 12'h001 << idx;
      prot = 12'($urandom);
      prot[idx] = n[0];
      sector_protect <= prot;
      a = 16'($urandom);
      d = 8'($urandom);
      prev = op_count;
      cmd(`FCS_CMD_PROG, s);
      wr(a, d, s);
      if (n[0]) no_op(prev);
      else begin
        expect_op(prev, fcs_pkg::OP_PROG, s, idx >= 8);
        chk(s_addr, a);
        chk(s_data, d);
        busy_chk(PROG);
      end
    end
    $display("test program done");
    // aborted sequences, no select and plain write
    sector_protect <= 12'h000;
    s = 12'h002;
    prev = op_count;
    cmd(8'h77, s);
    wr(a, d, s);
    cmd(8'hFF, s);
    repeat (3 * WIN) @(posedge sys_clk);
    wr(hi(`FCS_ADDR_555), `FCS_CMD_PROG, s);
    wr(a, d, s);
    cmd(`FCS_CMD_PROG, 12'h000);
    wr(a, d, 12'h000);
    wr(a, d, s);
    no_op(prev);
    $display("test abort done");
    // bulk erase of each array
    for (int k = 0; k < 2; k++) begin
      prot = 12'($urandom);
      prot[k * 8] = 1'b0;
      sector_protect <= prot;
      s = k[0] ? 12'h100 : 12'h001;
      prev = op_count;
      cmd(`FCS_CMD_ERASE, s);
      cmd(`FCS_CMD_BULK, s);
      expect_op(prev, fcs_pkg::OP_BULK_ERASE,
                k[0] ? {~prot[11:8], 8'h00} : {4'h0, ~prot[7:0]}, k[0]);
      busy_chk(ERASE);
    end
    $display("test bulk done");
    // queued sector erase with suspend and resume
    sector_protect <= 12'h004;
    wr(ev(), `FCS_CMD_SUSP, 12'h001);
    repeat (4) @(posedge sys_clk);
    chk(susp, 1'b0);
    prev = op_count;
    cmd(`FCS_CMD_ERASE, 12'h002);
    cmd(8'hFF, 12'h002);
    wr(16'($urandom), `FCS_CMD_SECT, 12'h002);
    wr(16'($urandom), `FCS_CMD_SECT, 12'h004);
    wr(16'($urandom), `FCS_CMD_SECT, 12'h010);
    expect_op(prev, fcs_pkg::OP_SECT_ERASE, 12'h012, 1'b0);
    wr(ev(), `FCS_CMD_SUSP, 12'h002);
    repeat (3) @(posedge sys_clk);
    chk(susp, 1'b1);
    chk(rb, `FCS_RB_READY);
    seg = last_busy;
    // programs while suspended: erasing sector refused, other sector runs
    prev = op_count;
    cmd(`FCS_CMD_PROG, 12'h002);
    wr(a, d, 12'h002);
    no_op(prev);
    cmd(`FCS_CMD_PROG, 12'h020);
    wr(a, d, 12'h020);
    expect_op(prev, fcs_pkg::OP_PROG, 12'h020, 1'b0);
    busy_chk(PROG);
    chk(susp, 1'b1);
    wr(ev(), `FCS_CMD_SECT, 12'h002);
    repeat (3) @(posedge sys_clk);
    chk(susp, 1'b0);
    chk(rb, `FCS_RB_BUSY);
    busy_chk(ERASE - seg);
    chk(rb, `FCS_RB_READY);
    $display("test sector erase done");
    // identifier and protection readout, then reset command
    sector_protect <= 12'h020;
    cmd(`FCS_CMD_AUTOSEL, 12'h001);
    i_fcs_host_model.rd((16'($urandom) & 16'hFFBC) | 16'h0001, 12'h001, d, ov);
    chk(d, ID);
    chk(ov, 1'b1);
    i_fcs_host_model.rd((16'($urandom) & 16'hFFBC) | 16'h0002, 12'h020, d, ov);
    chk(d, `FCS_PROT_YES);
    i_fcs_host_model.rd((16'($urandom) & 16'hFFBC) | 16'h0002, 12'h040, d, ov);
    chk(d, `FCS_PROT_NO);
    wr(ev(), `FCS_CMD_RESET, 12'h001);
    i_fcs_host_model.rd((16'($urandom) & 16'hFFBC) | 16'h0001, 12'h001, d, ov);
    chk(ov, 1'b0);
    $display("test readout done");
    // bypass: two back-to-back short programs, then exit
    sector_protect <= 12'h000;
    cmd(`FCS_CMD_BYPASS, 12'h008);
    for (int n = 0; n < 2; n++) begin
      a = 16'($urandom);
      d = 8'($urandom);
      prev = op_count;
      wr(ev(), `FCS_CMD_PROG, 12'h008);
      wr(a, d, 12'h008);
      expect_op(prev, fcs_pkg::OP_PROG, 12'h008, 1'b0);
      chk(s_data, d);
      busy_chk(PROG);
    end
    wr(ev(), `FCS_CMD_AUTOSEL, 12'h008);
    wr(ev(), `FCS_CMD_BYP_EXIT, 12'h008);
    prev = op_count;
    wr(ev(), `FCS_CMD_PROG, 12'h008);
    wr(a, d, 12'h008);
    no_op(prev);
    $display("test bypass done");
    end_sim();
  end
endmodule
